/* design/cfg_decode_regs.vh */
`ifndef CFG_DECODE_REGS_VH
`define CFG_DECODE_REGS_VH

// ---------------------------------------------------------------
// Register byte addresses
// ---------------------------------------------------------------
`define ADDR_POWER_UP 12'h000
`define ADDR_WATCHDOG 12'h004
`define ADDR_OSC_SELECT 12'h008
`define ADDR_STATUS 12'h00C
`define ADDR_CONTROL 12'h010
// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define POR_LPBOR_BIT 3
`define POR_RETREG_BIT 2
`define POR_BOR_HI 1
`define POR_BOR_LO 0
`define WDT_EN_BIT 15
`define WDT_CLK_HI 14
`define WDT_CLK_LO 13
`define WDT_RPS_HI 12
`define WDT_RPS_LO 8
`define WDT_WINDOW_MODE_DISABLE_BIT 7
`define WDT_WSZ_HI 6
`define WDT_WSZ_LO 5
`define WDT_SPS_HI 4
`define WDT_SPS_LO 0
`define OSC_FCKSM_HI 15
`define OSC_FCKSM_LO 14
`define OSC_SOSCXTAL_BIT 12
`define OSC_CLKO_BIT 10
`define OSC_PMODE_HI 9
`define OSC_PMODE_LO 8
`define OSC_TWOSPD_BIT 7
`define OSC_SECONDARY_OSC_ENABLE_BIT 6
`define OSC_PLL_REFERENCE_SELECT_BIT 4
`define OSC_INIT_HI 2
`define OSC_INIT_LO 0
// ---------------------------------------------------------------
// Reset values and codes
// ---------------------------------------------------------------
`define CFG_ERASED 32'hFFFF_FFFF
`define PS_MAX_CODE 5'h14
`define WDT_CLK_SYS 2'h0
`define WDT_CLK_RSV 2'h1
`define WDT_CLK_FRC 2'h2
`define WDT_CLK_LOW_POWER_RC_OSC 2'h3
`define INIT_FRC_DIV 3'h0
`define INIT_PLL 3'h1
`define INIT_PRIMARY 3'h2
`define INIT_RSV 3'h3
`define INIT_SECONDARY 3'h4
`define INIT_LOW_POWER_RC_OSC 3'h5
// Window opening fraction of timeout in eighths (closed part)
`define WIN_CLOSED_25 3'h6
`define WIN_CLOSED_375 3'h5
`define WIN_CLOSED_50 3'h4
`define WIN_CLOSED_75 3'h2
`endif

/* design/power_wdt_osc_config_decode.v */
`include "cfg_decode_regs.vh"

module power_wdt_osc_config_decode (
  // APB
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  // Nonvolatile words
  input wire [31:0] power_up_word_in,
  input wire [31:0] watchdog_word_in,
  input wire [31:0] osc_select_word_in,
  // Device state
  input wire sleep_mode,
  input wire software_brownout_control,
  input wire runtime_retention_control,
  input wire watchdog_clear,
  input wire [20:0] watchdog_count,
  input wire [20:0] watchdog_timeout,
  // Reset and power
  output reg brownout_reset_enable,
  output reg low_power_brownout_enable,
  output reg retention_regulator_enable,
  // Watchdog
  output reg watchdog_enable_cfg,
  output reg [1:0] watchdog_clock_source,
  output reg watchdog_clock_reserved,
  output reg [20:0] watchdog_divide_ratio,
  output reg watchdog_windowed,
  output reg [2:0] watchdog_window_closed_eighths,
  output reg watchdog_window_reset,
  // Oscillator
  output reg fail_safe_monitor_enable,
  output reg clock_switch_enable,
  output reg secondary_osc_external_clock,
  output reg secondary_osc_pins_to_io,
  output reg clock_out_enable,
  output reg [1:0] primary_osc_mode,
  output reg two_speed_startup_enable,
  output reg secondary_osc_enable,
  output reg pll_reference_fast_rc,
  output reg [2:0] initial_oscillator_select,
  output reg initial_oscillator_reserved
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Shared by run and sleep postscalers
  function [20:0] postscale_ratio;
    input [4:0] code;
    begin
      if (code >= `PS_MAX_CODE)
        postscale_ratio = 21'h10_0000;
      else
        postscale_ratio = 21'h00_0001 << code;
    end
  endfunction

  // ---------------------------------------------------------------
  // Configuration latch
  // ---------------------------------------------------------------
  // Words are captured once after reset release; a strap must not
  // reach an asynchronously reset flop directly.
  reg [31:0] por_q;
  reg [31:0] wdt_q;
  reg [31:0] osc_q;
  reg loaded_q;
  reg win_err_q;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      por_q <= `CFG_ERASED;
      wdt_q <= `CFG_ERASED;
      osc_q <= `CFG_ERASED;
      loaded_q <= 1'b0;
    end
    else if (!loaded_q)
    begin
      por_q <= power_up_word_in;
      wdt_q <= watchdog_word_in;
      osc_q <= osc_select_word_in;
      loaded_q <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  wire [1:0] bor_field = por_q[`POR_BOR_HI:`POR_BOR_LO];
  wire [1:0] run_clk = wdt_q[`WDT_CLK_HI:`WDT_CLK_LO];
  wire [4:0] run_ps = wdt_q[`WDT_RPS_HI:`WDT_RPS_LO];
  wire [4:0] sleep_ps = wdt_q[`WDT_SPS_HI:`WDT_SPS_LO];
  wire [1:0] win_sz = wdt_q[`WDT_WSZ_HI:`WDT_WSZ_LO];
  wire [2:0] init_osc = osc_q[`OSC_INIT_HI:`OSC_INIT_LO];
  reg bor_d;
  reg [2:0] closed_d;
  reg [2:0] init_d;

  always @*
  begin
    case (bor_field)
      2'b11: bor_d = 1'b1;
      2'b10: bor_d = ~sleep_mode;
      2'b01: bor_d = software_brownout_control;
      default: bor_d = 1'b0;
    endcase
    case (win_sz)
      2'b11: closed_d = `WIN_CLOSED_25;
      2'b10: closed_d = `WIN_CLOSED_375;
      2'b01: closed_d = `WIN_CLOSED_50;
      default: closed_d = `WIN_CLOSED_75;
    endcase
    // Reserved 110/111 fall back to divided fast RC
    if (init_osc[2] && init_osc[1])
      init_d = `INIT_FRC_DIV;
    else
      init_d = init_osc;
  end

  // Open window starts after closed_eighths/8 of the timeout
  wire [23:0] count_x8 = {watchdog_count, 3'b000};
  wire [23:0] closed_limit = watchdog_timeout * closed_d;
  wire early_clear = watchdog_enable_cfg && watchdog_windowed && watchdog_clear &&
                     (count_x8 < closed_limit);

  // ---------------------------------------------------------------
  // Registered outputs
  // ---------------------------------------------------------------
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      brownout_reset_enable <= 1'b1;
      low_power_brownout_enable <= 1'b0;
      retention_regulator_enable <= 1'b0;
      watchdog_enable_cfg <= 1'b0;
      watchdog_clock_source <= `WDT_CLK_SYS;
      watchdog_clock_reserved <= 1'b0;
      watchdog_divide_ratio <= 21'h00_0001;
      watchdog_windowed <= 1'b0;
      watchdog_window_closed_eighths <= `WIN_CLOSED_25;
      watchdog_window_reset <= 1'b0;
      win_err_q <= 1'b0;
      fail_safe_monitor_enable <= 1'b0;
      clock_switch_enable <= 1'b0;
      secondary_osc_external_clock <= 1'b0;
      secondary_osc_pins_to_io <= 1'b0;
      clock_out_enable <= 1'b0;
      primary_osc_mode <= 2'b11;
      two_speed_startup_enable <= 1'b0;
      secondary_osc_enable <= 1'b0;
      pll_reference_fast_rc <= 1'b1;
      initial_oscillator_select <= `INIT_FRC_DIV;
      initial_oscillator_reserved <= 1'b0;
    end
    else
    begin
      brownout_reset_enable <= bor_d;
      low_power_brownout_enable <= por_q[`POR_LPBOR_BIT] & ~bor_d;
      retention_regulator_enable <= ~por_q[`POR_RETREG_BIT] &
                                    sleep_mode & runtime_retention_control;
      watchdog_enable_cfg <= wdt_q[`WDT_EN_BIT];
      watchdog_clock_source <= sleep_mode ? `WDT_CLK_LOW_POWER_RC_OSC : run_clk;
      watchdog_clock_reserved <= (run_clk == `WDT_CLK_RSV);
      watchdog_divide_ratio <= postscale_ratio(sleep_mode ? sleep_ps : run_ps);
      watchdog_windowed <= ~wdt_q[`WDT_WINDOW_MODE_DISABLE_BIT];
      watchdog_window_closed_eighths <= closed_d;
      // Sticky until next reset
      win_err_q <= win_err_q | early_clear;
      watchdog_window_reset <= early_clear;
      fail_safe_monitor_enable <= osc_q[`OSC_FCKSM_HI];
      clock_switch_enable <= osc_q[`OSC_FCKSM_LO];
      secondary_osc_external_clock <= ~osc_q[`OSC_SOSCXTAL_BIT];
      secondary_osc_pins_to_io <= ~osc_q[`OSC_SOSCXTAL_BIT];
      clock_out_enable <= ~osc_q[`OSC_CLKO_BIT];
      primary_osc_mode <= osc_q[`OSC_PMODE_HI:`OSC_PMODE_LO];
      two_speed_startup_enable <= osc_q[`OSC_TWOSPD_BIT];
      secondary_osc_enable <= osc_q[`OSC_SECONDARY_OSC_ENABLE_BIT];
      pll_reference_fast_rc <= osc_q[`OSC_PLL_REFERENCE_SELECT_BIT];
      initial_oscillator_select <= init_d;
      initial_oscillator_reserved <= (init_osc == `INIT_RSV);
    end
  end

  // ---------------------------------------------------------------
  // APB slave
  // ---------------------------------------------------------------
  // Zero wait states; all registers read-only, writes answered with pslverr
  assign pready = 1'b1;
  wire rd_en = psel & penable & ~pwrite;
  wire hit = (paddr == `ADDR_POWER_UP) || (paddr == `ADDR_WATCHDOG) ||
             (paddr == `ADDR_OSC_SELECT) || (paddr == `ADDR_STATUS);
  assign pslverr = psel & penable & (pwrite | ~hit);

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (psel & ~penable & ~pwrite)
    begin
      if (paddr == `ADDR_POWER_UP)
        prdata <= por_q;
      else if (paddr == `ADDR_WATCHDOG)
        prdata <= wdt_q;
      else if (paddr == `ADDR_OSC_SELECT)
        prdata <= osc_q;
      else if (paddr == `ADDR_STATUS)
        prdata <= {28'h000_0000, initial_oscillator_reserved, watchdog_clock_reserved,
                   win_err_q, loaded_q};
      else
        prdata <= 32'h0000_0000;
    end
  end

  wire unused_rd = rd_en;
endmodule

/* dv/cfg_programmer.sv */
module cfg_programmer (
  // Programmable fields
  input wire logic [3:0] por_bits,
  input wire logic [15:0] wdt_bits,
  input wire logic [15:0] osc_bits,
  // Words as stored
  output logic [31:0] por_word,
  output logic [31:0] wdt_word,
  output logic [31:0] osc_word
);
  timeunit 1ns;
  timeprecision 1ps;
  assign por_word = {28'hFFF_FFFF, por_bits};
  assign wdt_word = {16'hFFFF, wdt_bits};
  // Reserved slots forced high, whatever the caller asks for
  assign osc_word = {16'hFFFF, osc_bits | 16'h2828};
endmodule

/* dv/cfg_decode_chk.sv */
module cfg_decode_chk (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Stored words and state
  input wire logic [31:0] power_up_word_in,
  input wire logic [31:0] watchdog_word_in,
  input wire logic [31:0] osc_select_word_in,
  input wire logic sleep_mode,
  // Decoded outputs
  input wire logic pslverr,
  input wire logic brownout_reset_enable,
  input wire logic watchdog_enable_cfg,
  input wire logic [20:0] watchdog_divide_ratio,
  input wire logic watchdog_windowed,
  input wire logic watchdog_window_reset,
  input wire logic clock_out_enable,
  input wire logic [1:0] primary_osc_mode
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] up_q;
  function automatic logic [20:0] ratio(input logic [4:0] c);
    ratio = (c > 5'h13) ? 21'h10_0000 : 21'h00_0001 << c;
  endfunction
  // Words are latched once, so checks wait until decode has settled
  always @(posedge pclk or negedge presetn)
    if (!presetn)
      up_q <= 2'h0;
    else if (up_q != 2'h3)
      up_q <= up_q + 2'h1;
  wire ok = up_q == 2'h3;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_wdt_en; ok |-> watchdog_enable_cfg == watchdog_word_in[15]; endproperty
  a_wdt_en: assert property (p_wdt_en) else $error("wdt enable");
  property p_windowed; ok |-> watchdog_windowed != watchdog_word_in[7]; endproperty
  a_windowed: assert property (p_windowed) else $error("windowed");
  property p_clk_out; ok |-> clock_out_enable != osc_select_word_in[10]; endproperty
  a_clk_out: assert property (p_clk_out) else $error("clock out");
  property p_pmode; ok |-> (primary_osc_mode == osc_select_word_in[9:8]) [*2]; endproperty
  a_pmode: assert property (p_pmode) else $error("primary mode");
  property p_run_ratio;
    ok && !$past(sleep_mode) |-> watchdog_divide_ratio == ratio(watchdog_word_in[12:8]);
  endproperty
  a_run_ratio: assert property (p_run_ratio) else $error("run ratio");
  property p_sleep_ratio;
    ok && $past(sleep_mode) |-> watchdog_divide_ratio == ratio(watchdog_word_in[4:0]);
  endproperty
  a_sleep_ratio: assert property (p_sleep_ratio) else $error("sleep ratio");
  property p_bor_on; ok && power_up_word_in[1:0] == 2'h3 |-> brownout_reset_enable; endproperty
  a_bor_on: assert property (p_bor_on) else $error("bor on");
  property p_bor_off; ok && power_up_word_in[1:0] == 2'h0 |-> !brownout_reset_enable; endproperty
  a_bor_off: assert property (p_bor_off) else $error("bor off");
  c_win: cover property (watchdog_window_reset);
  c_sleep: cover property (ok && sleep_mode);
  c_err: cover property (pslverr);
endmodule

bind power_wdt_osc_config_decode cfg_decode_chk u_cfg_decode_chk (.pclk, .presetn,
  .power_up_word_in, .watchdog_word_in, .osc_select_word_in, .sleep_mode, .pslverr,
  .brownout_reset_enable, .watchdog_enable_cfg, .watchdog_divide_ratio, .watchdog_windowed,
  .watchdog_window_reset, .clock_out_enable, .primary_osc_mode);

/* dv/power_wdt_osc_config_decode_test.sv */
module power_wdt_osc_config_decode_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic sleep_mode = 0, sbor = 0, rrc = 0, wclr = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [20:0] wcnt = 21'h00_0000, wtmo = 21'h00_0320;
  logic [3:0] por_b = 4'hF;
  logic [15:0] wdt_b = 16'hFFFF, osc_b = 16'hFFFF;
  wire [31:0] por_w, wdt_w, osc_w, prdata;
  wire pready, pslverr, bre, lpbe, rre, wen, wclkr, wwin, wrst, fsm, cse, sxc, spio, coe;
  wire tsu, soe, pll, irsv;
  wire [1:0] wclk, pmode;
  wire [20:0] ratio;
  wire [2:0] wcl, iosc;
  logic [33:0] q[$];
  logic [33:0] e;
  int fails = 0, checks = 0, k = 0;
  always #12.5 pclk = ~pclk;
  cfg_programmer u_cfg_programmer (.por_bits(por_b), .wdt_bits(wdt_b), .osc_bits(osc_b),
    .por_word(por_w), .wdt_word(wdt_w), .osc_word(osc_w));
  power_wdt_osc_config_decode u_power_wdt_osc_config_decode (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .power_up_word_in(por_w),
    .watchdog_word_in(wdt_w), .osc_select_word_in(osc_w), .sleep_mode,
    .software_brownout_control(sbor), .runtime_retention_control(rrc), .watchdog_clear(wclr),
    .watchdog_count(wcnt), .watchdog_timeout(wtmo), .brownout_reset_enable(bre),
    .low_power_brownout_enable(lpbe), .retention_regulator_enable(rre),
    .watchdog_enable_cfg(wen), .watchdog_clock_source(wclk), .watchdog_clock_reserved(wclkr),
    .watchdog_divide_ratio(ratio), .watchdog_windowed(wwin),
    .watchdog_window_closed_eighths(wcl), .watchdog_window_reset(wrst),
    .fail_safe_monitor_enable(fsm), .clock_switch_enable(cse),
    .secondary_osc_external_clock(sxc), .secondary_osc_pins_to_io(spio),
    .clock_out_enable(coe), .primary_osc_mode(pmode), .two_speed_startup_enable(tsu),
    .secondary_osc_enable(soe), .pll_reference_fast_rc(pll), .initial_oscillator_select(iosc),
    .initial_oscillator_reserved(irsv));
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("BAD %0t %h %h", $time, seen, exp);
    end
  endtask
  task report_and_stop;
    if (fails == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task apb(input logic wr, input logic [11:0] a, input logic [32:0] x);
    int n;
    q.push_back({wr, x});
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= $urandom;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1)
    begin
      fails++;
      report_and_stop;
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Writes carry no data to compare, only the refusal
  always @(posedge pclk)
    if (psel && penable && pready === 1'b1)
    begin
      e = q.pop_front();
      check(pslverr, e[32]);
      if (!e[33])
        check(prdata, e[31:0]);
    end
  task dec(input logic s);
    logic [4:0] ps;
    logic [1:0] f;
    logic b;
    f = por_b[1:0];
    ps = s ? wdt_b[4:0] : wdt_b[12:8];
    b = f == 2'h3 || (f == 2'h2 && !s) || (f == 2'h1 && sbor);
    k = wdt_b[6:5] == 2'h0 ? 2 : wdt_b[6:5] + 3;
    check({bre, lpbe}, {b, por_b[3] && !b});
    check(rre, !por_b[2] && s && rrc);
    check({wen, wwin, wclk}, {wdt_b[15], !wdt_b[7], s ? 2'h3 : wdt_b[14:13]});
    if (!s)
      check(wclkr, wdt_b[14:13] == 2'h1);
    check(ratio, ps > 5'h13 ? 32'h0010_0000 : 32'h0000_0001 << ps);
    check(wcl, k);
    check({fsm, cse, sxc, spio, coe, pmode}, {osc_b[15:14], {2{!osc_b[12]}}, !osc_b[10], osc_b[9:8]});
    check({tsu, soe, pll}, {osc_b[7:6], osc_b[4]});
    check({irsv, iosc}, {osc_b[2:0] == 3'h3, osc_b[2:1] == 2'h3 ? 3'h0 : osc_b[2:0]});
  endtask
  initial
  begin
    int i, c;
    void'($urandom(32'h3ce4614b));
    repeat (16) @(posedge pclk);
    for (i = 0; i < 32; i++)
    begin
      presetn <= 1'b0;
      por_b <= {2'($urandom), i[1:0]};
      wdt_b <= {1'($urandom), i[1:0], i[4:0], 1'($urandom), i[3:2], ~i[4:0]};
      osc_b <= {13'($urandom), i[2:0]};
      sbor <= 1'($urandom);
      rrc <= 1'($urandom);
      sleep_mode <= 1'b0;
      c = $urandom_range(799, 0);
      wcnt <= 21'(c);
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      repeat (3) @(posedge pclk);
      @(negedge pclk);
      dec(1'b0);
      @(posedge pclk);
      apb(1'b1, 12'h004, {1'b1, 32'h0000_0000});
      apb(1'b0, 12'h000, {1'b0, 28'hFFF_FFFF, por_b});
      apb(1'b0, 12'h004, {1'b0, 16'hFFFF, wdt_b});
      apb(1'b0, 12'h008, {1'b0, 16'hFFFF, osc_b | 16'h2828});
      apb(1'b0, 12'h010, {1'b1, 32'h0000_0000});
      wclr <= 1'b1;
      @(posedge pclk);
      wclr <= 1'b0;
      @(negedge pclk);
      check(wrst, wdt_b[15] && !wdt_b[7] && c * 8 < 800 * k);
      @(posedge pclk);
      apb(1'b0, 12'h00C, {1'b0, 28'h000_0000, osc_b[2:0] == 3'h3, wdt_b[14:13] == 2'h1,
        wdt_b[15] && !wdt_b[7] && c * 8 < 800 * k, 1'b1});
      sleep_mode <= 1'b1;
      repeat (2) @(posedge pclk);
      @(negedge pclk);
      dec(1'b1);
      @(posedge pclk);
    end
    report_and_stop;
  end
endmodule
